// File: hdl/pscir_regs.sv
// Purpose: vendor management registers 27, 29, 30, 31 of a 10/100 phy
// Assumes: management frame logic presents index, strobes and data on REF_CLK
// Notes: read data and valid arrive one cycle after the read strobe
// How it works
// - override clear means strap picks crossover; set means register bits decide.
// - auto-crossover enable counts only under override; zero hands over to manual.
// - manual state zero keeps pairs straight, one swaps transmit and receive.
// - pll force bit holds 10M receive pll on reference, blocking 10M reception.
// - read-only bit reports 10BASE-T receive polarity, one when reversed.
// - low four bits of register 27 ignore writes.
// - reserved bits 12:11 and 9-5 of register 27 hold zero.
// - flag register latches energy, negotiation, fault, link down, ack, page events.
// - link down flag follows line state after reset; other flags reset zero.
// - eight-bit mask cleared at reset; one enables a source; upper byte zero.
// - negotiation-done bit reads one once auto-negotiation has finished.
// - bits 4-2 report resolved speed and duplex code.
// - reserved bits 11-5 of register 31 reset to and hold written pattern.
// - energy present clears after 256 ms without energy; reset sets it.
`include "pscir_consts.svh"

module pscir_regs #(
  parameter int ENERGY_TIMEOUT_CYCLES = `PSCIR_ENERGY_TMO_MS * (`PSCIR_CLK_HZ / 1000)
) (
  input  wire logic                     REF_CLK,
  input  wire logic                     RESET,
  input  wire logic                     SOFT_RESET,
  input  wire logic [4:0]               REG_ADDR,
  input  wire logic                     REG_WR,
  input  wire logic [15:0]              REG_WDATA,
  input  wire logic                     REG_RD,
  output logic      [15:0]              REG_RDATA,
  output logic                          REG_RVALID,
  input  wire logic                     CROSSOVER_STRAP,
  input  wire logic                     LINE_ENERGY,
  input  wire logic                     LINK_UP,
  input  wire pscir_pkg::pscir_events_t EVENTS,
  input  wire pscir_pkg::pscir_status_t STATUS,
  output logic                          MDIX_AUTO_EN,
  output logic                          MDIX_SWAP,
  output logic                          RX_PLL_FORCE_REFERENCE,
  output logic                          ENERGY_PRESENT,
  output logic                          PHY_IRQ
);

  logic [1:0]                pin_sync;
  logic                      strap_s;
  logic                      energy_s;
  logic                      override;
  logic                      auto_en;
  logic                      manual_swap;
  logic                      pll_force;
  logic [7:0]                mask;
  logic [6:0]                rsv31;
  logic [7:0]                flags;
  logic                      energy_present;
  logic                      energy_prev;
  logic                      link_prev;
  logic [`PSCIR_TMO_W-1:0]   quiet_cnt;
  logic [15:0]               rdata;
  logic                      rvalid;
  logic                      mdix_auto;
  logic                      mdix_swap;
  logic                      irq;
  logic                      next_override;
  logic                      next_auto_en;
  logic                      next_manual_swap;
  logic                      next_pll_force;
  logic [7:0]                next_mask;
  logic [6:0]                next_rsv31;
  logic [7:0]                next_flags;
  logic [7:0]                flag_events;
  logic                      next_energy_present;
  logic [`PSCIR_TMO_W-1:0]   next_quiet_cnt;
  logic [15:0]               next_rdata;
  logic                      next_rvalid;
  logic                      next_mdix_auto;
  logic                      next_mdix_swap;
  logic                      next_irq;
  logic                      wr_ctrl;
  logic                      wr_mask;
  logic                      wr_stat;
  logic                      rd_flags;

  localparam logic [`PSCIR_TMO_W-1:0] QUIET_LAST = `PSCIR_TMO_W'(ENERGY_TIMEOUT_CYCLES - 1);

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] idx, input logic strobe);
    hit = strobe && (addr == idx);
  endfunction

  pscir_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (REF_CLK),
    .rst      (RESET),
    .async_in ({CROSSOVER_STRAP, LINE_ENERGY}),
    .sync_out (pin_sync)
  );

  assign strap_s  = pin_sync[1];
  assign energy_s = pin_sync[0];
  assign wr_ctrl  = hit(REG_ADDR, `PSCIR_IDX_CTRL, REG_WR);
  assign wr_mask  = hit(REG_ADDR, `PSCIR_IDX_MASK, REG_WR);
  assign wr_stat  = hit(REG_ADDR, `PSCIR_IDX_STAT, REG_WR);
  assign rd_flags = hit(REG_ADDR, `PSCIR_IDX_FLAGS, REG_RD);

  // control and mask registers; pll force survives a soft reset
  always_comb
  begin
    next_override    = override;
    next_auto_en     = auto_en;
    next_manual_swap = manual_swap;
    next_pll_force   = pll_force;
    next_mask        = mask;
    next_rsv31       = rsv31;
    if (SOFT_RESET)
    begin
      next_override    = 1'b0;
      next_auto_en     = 1'b0;
      next_manual_swap = 1'b0;
      next_mask        = 8'h00;
      next_rsv31       = `PSCIR_RSV_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // writes to bits 12:11, 9:5 and 3:0 land nowhere
        next_override    = REG_WDATA[`PSCIR_B_OVERRIDE];
        next_auto_en     = REG_WDATA[`PSCIR_B_AUTO_EN];
        next_manual_swap = REG_WDATA[`PSCIR_B_MANUAL];
        next_pll_force   = REG_WDATA[`PSCIR_B_PLL_FORCE];
      end
      if (wr_mask)
      begin
        next_mask = REG_WDATA[7:0];
      end
      if (wr_stat)
      begin
        next_rsv31 = REG_WDATA[`PSCIR_RSV_HI:`PSCIR_RSV_LO];
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      override    <= 1'b0;
      auto_en     <= 1'b0;
      manual_swap <= 1'b0;
      pll_force   <= 1'b0;
      mask        <= 8'h00;
      rsv31       <= `PSCIR_RSV_RESET;
    end
    else
    begin
      override    <= next_override;
      auto_en     <= next_auto_en;
      manual_swap <= next_manual_swap;
      pll_force   <= next_pll_force;
      mask        <= next_mask;
      rsv31       <= next_rsv31;
    end
  end

  // crossover selection; the forbidden all-ones combination degrades to automatic
  always_comb
  begin
    if (!override)
    begin
      next_mdix_auto = strap_s;
      next_mdix_swap = 1'b0;
    end
    else
    begin
      next_mdix_auto = auto_en;
      next_mdix_swap = !auto_en && manual_swap;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      mdix_auto <= 1'b0;
      mdix_swap <= 1'b0;
    end
    else
    begin
      mdix_auto <= next_mdix_auto;
      mdix_swap <= next_mdix_swap;
    end
  end

  // energy detect: hardware reset sets it, soft reset leaves it alone
  always_comb
  begin
    next_energy_present = energy_present;
    next_quiet_cnt      = quiet_cnt;
    if (energy_s)
    begin
      next_energy_present = 1'b1;
      next_quiet_cnt      = '0;
    end
    else if (quiet_cnt == QUIET_LAST)
    begin
      next_energy_present = 1'b0;
    end
    else
    begin
      next_quiet_cnt = quiet_cnt + `PSCIR_TMO_W'(1);
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      energy_present <= 1'b1;
      quiet_cnt      <= '0;
    end
    else
    begin
      energy_present <= next_energy_present;
      quiet_cnt      <= next_quiet_cnt;
    end
  end

  // latched-high flags; an event in the clearing cycle still lands
  always_comb
  begin
    flag_events                     = 8'h00;
    flag_events[`PSCIR_F_ENERGY]    = energy_present && !energy_prev;
    flag_events[`PSCIR_F_NEG_DONE]  = EVENTS.negotiation_complete;
    flag_events[`PSCIR_F_REMOTE]    = EVENTS.remote_fault;
    flag_events[`PSCIR_F_LINK_DOWN] = link_prev && !LINK_UP;
    flag_events[`PSCIR_F_PARTNER]   = EVENTS.partner_acknowledge;
    flag_events[`PSCIR_F_PARALLEL]  = EVENTS.parallel_detect_fault;
    flag_events[`PSCIR_F_PAGE]      = EVENTS.page_received;
    next_flags = (rd_flags ? 8'h00 : flags) | flag_events;
    next_irq   = |(flags & mask);
  end

  // link_prev resets high so a line already down latches its flag right after reset
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      flags       <= 8'h00;
      energy_prev <= 1'b1;
      link_prev   <= 1'b1;
      irq         <= 1'b0;
    end
    else
    begin
      flags       <= next_flags;
      energy_prev <= energy_present;
      link_prev   <= LINK_UP;
      irq         <= next_irq;
    end
  end

  // read mux; unused indices and register 27 reserved bits read zero; register 31 reserved bits read rsv31
  always_comb
  begin
    next_rdata  = 16'h0000;
    next_rvalid = REG_RD;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        `PSCIR_IDX_CTRL:
        begin
          next_rdata[`PSCIR_B_OVERRIDE]  = override;
          next_rdata[`PSCIR_B_AUTO_EN]   = auto_en;
          next_rdata[`PSCIR_B_MANUAL]    = manual_swap;
          next_rdata[`PSCIR_B_PLL_FORCE] = pll_force;
          next_rdata[`PSCIR_B_POLARITY]  = STATUS.rx_polarity_reversed;
        end
        `PSCIR_IDX_FLAGS:
        begin
          next_rdata[7:0] = flags;
        end
        `PSCIR_IDX_MASK:
        begin
          next_rdata[7:0] = mask;
        end
        `PSCIR_IDX_STAT:
        begin
          next_rdata[`PSCIR_B_DONE]                    = STATUS.negotiation_done;
          next_rdata[`PSCIR_RSV_HI:`PSCIR_RSV_LO]      = rsv31;
          next_rdata[`PSCIR_MODE_HI:`PSCIR_MODE_LO]    = STATUS.resolved_link_mode;
        end
        default:
        begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign REG_RDATA              = rdata;
  assign REG_RVALID             = rvalid;
  assign MDIX_AUTO_EN           = mdix_auto;
  assign MDIX_SWAP              = mdix_swap;
  assign RX_PLL_FORCE_REFERENCE = pll_force;
  assign ENERGY_PRESENT         = energy_present;
  assign PHY_IRQ                = irq;

endmodule

// File: hdl/pscir_consts.svh
// Purpose: named constants for the phy special control and interrupt registers
// Assumes: 16-bit management registers reached by 5-bit index
// Notes: included by the register bank and its package users
`ifndef PSCIR_CONSTS_SVH
`define PSCIR_CONSTS_SVH

`define PSCIR_IDX_CTRL      5'h1b
`define PSCIR_IDX_FLAGS     5'h1d
`define PSCIR_IDX_MASK      5'h1e
`define PSCIR_IDX_STAT      5'h1f

`define PSCIR_B_OVERRIDE    15
`define PSCIR_B_AUTO_EN     14
`define PSCIR_B_MANUAL      13
`define PSCIR_B_PLL_FORCE   10
`define PSCIR_B_POLARITY    4
`define PSCIR_B_DONE        12
`define PSCIR_MODE_HI       4
`define PSCIR_MODE_LO       2
`define PSCIR_RSV_HI        11
`define PSCIR_RSV_LO        5
`define PSCIR_RSV_RESET     7'h02

`define PSCIR_F_ENERGY      7
`define PSCIR_F_NEG_DONE    6
`define PSCIR_F_REMOTE      5
`define PSCIR_F_LINK_DOWN   4
`define PSCIR_F_PARTNER     3
`define PSCIR_F_PARALLEL    2
`define PSCIR_F_PAGE        1

`define PSCIR_CLK_HZ        100000000
`define PSCIR_ENERGY_TMO_MS 256
`define PSCIR_TMO_W         25

`endif

// File: hdl/pscir_pkg.sv
// Purpose: types shared by the phy special register bank
// Assumes: nothing beyond the constants header
// Notes: link mode codes are the resolved speed and duplex
package pscir_pkg;

  typedef enum logic [2:0]
  {
    PSCIR_MODE_10_HALF  = 3'h1,
    PSCIR_MODE_10_FULL  = 3'h5,
    PSCIR_MODE_100_HALF = 3'h2,
    PSCIR_MODE_100_FULL = 3'h6
  } pscir_mode_t;

  typedef struct packed
  {
    logic negotiation_complete;
    logic remote_fault;
    logic partner_acknowledge;
    logic parallel_detect_fault;
    logic page_received;
  } pscir_events_t;

  typedef struct packed
  {
    logic        rx_polarity_reversed;
    logic        negotiation_done;
    pscir_mode_t resolved_link_mode;
  } pscir_status_t;

endpackage

// File: hdl/pscir_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to REF_CLK
// Notes: output moves only when stages two and three agree
module pscir_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  always_comb
  begin
    next_sync_out = sync_out;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2[i] == stage3[i])
      begin
        next_sync_out[i] = stage3[i];
      end
    end
  end

  // stage1 feeds only stage2, keeping metastability out of the filter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// File: testbench/pscir_regs_props.sv
// Purpose: port checker for the phy special register bank
// Assumes: one REF_CLK domain, writes take effect on the strobe edge
// Notes: control bits are shadowed from writes seen at the port
module pscir_regs_props #(
  parameter int ENERGY_TIMEOUT_CYCLES = 16
) (
  input wire logic                     REF_CLK,
  input wire logic                     RESET,
  input wire logic                     SOFT_RESET,
  input wire logic [4:0]               REG_ADDR,
  input wire logic                     REG_WR,
  input wire logic [15:0]              REG_WDATA,
  input wire logic                     REG_RD,
  input wire logic [15:0]              REG_RDATA,
  input wire logic                     REG_RVALID,
  input wire logic                     CROSSOVER_STRAP,
  input wire logic                     LINE_ENERGY,
  input wire logic                     LINK_UP,
  input wire pscir_pkg::pscir_events_t EVENTS,
  input wire pscir_pkg::pscir_status_t STATUS,
  input wire logic                     MDIX_AUTO_EN,
  input wire logic                     MDIX_SWAP,
  input wire logic                     RX_PLL_FORCE_REFERENCE,
  input wire logic                     ENERGY_PRESENT,
  input wire logic                     PHY_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ovr, aut, man, pll, swp;
  logic [7:0] mask;
  logic [4:0] ra;
  int         quiet;
  assign swp = ovr & ~aut & man;
  always_ff @(posedge REF_CLK)
  begin
    if (REG_RD)
      ra <= REG_ADDR;
    if (RESET || SOFT_RESET)
      {ovr, aut, man, mask} <= '0;
    else if (REG_WR && REG_ADDR == 5'h1b)
      {ovr, aut, man} <= REG_WDATA[15:13];
    else if (REG_WR && REG_ADDR == 5'h1e)
      mask <= REG_WDATA[7:0];
    // pll force survives soft reset
    if (RESET)
      pll <= 1'b0;
    else if (REG_WR && REG_ADDR == 5'h1b)
      pll <= REG_WDATA[10];
    // saturate just past the checked count so the antecedent fires once for any timeout
    quiet <= (RESET || LINE_ENERGY) ? 0 : (quiet < ENERGY_TIMEOUT_CYCLES + 9 ? quiet + 1 : quiet);
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // strap gets slack for its synchroniser
  a_strap_follow: assert property ((!ovr && $stable(CROSSOVER_STRAP))[*8] |-> MDIX_AUTO_EN == CROSSOVER_STRAP)
    else $error("auto crossover ignores strap");
  a_override_auto: assert property ($past(ovr) |-> MDIX_AUTO_EN == $past(aut))
    else $error("auto crossover ignores enable bit");
  a_manual_swap: assert property (MDIX_SWAP == $past(swp))
    else $error("pair swap wrong");
  a_pll_force: assert property (pll == $past(pll) |-> RX_PLL_FORCE_REFERENCE == pll)
    else $error("pll force not applied");
  a_ctrl_fields: assert property (REG_RVALID && ra == 5'h1b |-> REG_RDATA[15:5] == {$past(ovr), $past(aut), $past(man), 2'h0, $past(pll), 5'h00} && REG_RDATA[3:0] == 4'h0)
    else $error("control read wrong");
  a_polarity_bit: assert property (REG_RVALID && ra == 5'h1b |-> REG_RDATA[4] == $past(STATUS.rx_polarity_reversed))
    else $error("polarity bit wrong");
  a_mask_read: assert property (REG_RVALID && ra == 5'h1e |-> REG_RDATA == {8'h00, $past(mask)})
    else $error("mask read wrong");
  a_irq_masked: assert property (mask == 8'h00 && $past(mask) == 8'h00 |-> !PHY_IRQ)
    else $error("interrupt while all masked");
  a_status_read: assert property (REG_RVALID && ra == 5'h1f |-> REG_RDATA[15:12] == {3'h0, $past(STATUS.negotiation_done)} && REG_RDATA[4:0] == {$past(STATUS.resolved_link_mode), 2'h0})
    else $error("status read wrong");
  a_energy_quiet: assert property (quiet == ENERGY_TIMEOUT_CYCLES + 8 |-> !ENERGY_PRESENT)
    else $error("energy present after quiet line");
endmodule

bind pscir_regs pscir_regs_props #(.ENERGY_TIMEOUT_CYCLES(ENERGY_TIMEOUT_CYCLES)) i_pscir_regs_props (
  .REF_CLK(REF_CLK), .RESET(RESET), .SOFT_RESET(SOFT_RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CROSSOVER_STRAP(CROSSOVER_STRAP), .LINE_ENERGY(LINE_ENERGY), .LINK_UP(LINK_UP), .EVENTS(EVENTS),
  .STATUS(STATUS), .MDIX_AUTO_EN(MDIX_AUTO_EN), .MDIX_SWAP(MDIX_SWAP),
  .RX_PLL_FORCE_REFERENCE(RX_PLL_FORCE_REFERENCE), .ENERGY_PRESENT(ENERGY_PRESENT), .PHY_IRQ(PHY_IRQ)
);

// File: testbench/pscir_host.sv
// Purpose: management host model driving index, strobes and data
// Assumes: requests change on the falling edge
// Notes: raw writes skip the host write rules on purpose
module pscir_host (
  input  wire logic  clk,
  output logic [4:0]  addr,
  output logic        wr,
  output logic [15:0] wdata,
  output logic        rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {addr, wr, wdata, rd} = '0;
  end
  task automatic write(input logic [4:0] a, input logic [15:0] d, input logic raw);
    logic [15:0] v;
    v = d;
    if (!raw && a == 5'h1b)
      v = v & 16'he400;
    if (!raw && a == 5'h1b && v[14])
      v[13] = 1'b0;
    if (!raw && a == 5'h1f)
      v[11:5] = 7'h02;
    @(negedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(negedge clk);
    wr <= 1'b0;
    // released lines never keep the old value
    wdata <= ~v;
    addr <= ~a;
  endtask
  task automatic read(input logic [4:0] a);
    @(negedge clk);
    addr <= a;
    rd <= 1'b1;
    @(negedge clk);
    rd <= 1'b0;
    addr <= ~a;
  endtask
endmodule

// File: testbench/pscir_regs_test.sv
// Purpose: self-checking bench for the phy special register bank
// Assumes: short energy timeout of 16 cycles
// Notes: reads queue their expectation, a monitor compares
module pscir_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, reset = 1, soft_reset = 0, strap = 0, energy = 1, link_up = 0;
  logic wr, rd, rvalid, auto_en, swap, pll_ref, energy_present, irq;
  logic [4:0] addr, ev;
  logic [15:0] wdata, rdata;
  logic [15:0] exp_q[$];
  logic [7:0] seed = 8'h23;
  int miscompares = 0, total_checks = 0;
  pscir_pkg::pscir_events_t events = '0;
  pscir_pkg::pscir_status_t status = '0;
  always #5 ref_clk = ~ref_clk;
  pscir_host i_pscir_host (.clk(ref_clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd));
  pscir_regs #(.ENERGY_TIMEOUT_CYCLES(16)) i_pscir_regs (
    .REF_CLK(ref_clk), .RESET(reset), .SOFT_RESET(soft_reset), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .CROSSOVER_STRAP(strap),
    .LINE_ENERGY(energy), .LINK_UP(link_up), .EVENTS(events), .STATUS(status), .MDIX_AUTO_EN(auto_en),
    .MDIX_SWAP(swap), .RX_PLL_FORCE_REFERENCE(pll_ref), .ENERGY_PRESENT(energy_present), .PHY_IRQ(irq)
  );
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0, got}, {15'h0, exp});
  endtask
  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_pscir_host.read(a);
  endtask
  // an answer with nothing queued compares against unknown and fails
  // sampled mid-cycle, where the registered answer has settled
  always @(negedge ref_clk)
    if (rvalid === 1'b1)
      chk16(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial
  begin
    status.resolved_link_mode = pscir_pkg::PSCIR_MODE_10_HALF;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    repeat (5) @(negedge ref_clk);
    rd_exp(5'h1d, 16'h0010);
    rd_exp(5'h1d, 16'h0000);
    link_up = 1'b1;
    rd_exp(5'h1e, 16'h0000);
    rd_exp(5'h1f, 16'h0044);
    rd_exp(5'h1c, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      status.rx_polarity_reversed = seed[0];
      status.negotiation_done = seed[1];
      status.resolved_link_mode = pscir_pkg::pscir_mode_t'({i[1], i[0] ? 2'h2 : 2'h1});
      rd_exp(5'h1f, {3'h0, seed[1], 7'h02, i[1], i[0] ? 2'h2 : 2'h1, 2'h0});
      rd_exp(5'h1b, {11'h0, seed[0], 4'h0});
    end
    // all legal override, enable and manual codes
    for (int i = 0; i < 7; i++)
    begin
      strap = ~strap;
      i_pscir_host.write(5'h1b, {i[2:0], 13'h0400}, 1'b0);
      repeat (8) @(negedge ref_clk);
      chk1(auto_en, i[2] ? i[1] : strap);
      chk1(swap, i[2] & ~i[1] & i[0]);
      chk1(pll_ref, 1'b1);
    end
    i_pscir_host.write(5'h1b, 16'h1bef, 1'b1);
    rd_exp(5'h1b, {11'h0, status.rx_polarity_reversed, 4'h0});
    i_pscir_host.write(5'h1e, 16'hfffe, 1'b1);
    rd_exp(5'h1e, 16'h00fe);
    seed = lfsr(seed);
    ev = seed[4:0] | 5'h01;
    events = pscir_pkg::pscir_events_t'(ev);
    link_up = 1'b0;
    @(negedge ref_clk);
    events = '0;
    repeat (3) @(negedge ref_clk);
    chk1(irq, 1'b1);
    rd_exp(5'h1d, {9'h0, ev[4:3], 1'b1, ev[2:0], 1'b0});
    repeat (3) @(negedge ref_clk);
    chk1(irq, 1'b0);
    i_pscir_host.write(5'h1e, 16'h0000, 1'b0);
    events = '1;
    @(negedge ref_clk);
    events = '0;
    repeat (3) @(negedge ref_clk);
    chk1(irq, 1'b0);
    rd_exp(5'h1d, 16'h006e);
    energy = 1'b0;
    repeat (30) @(negedge ref_clk);
    chk1(energy_present, 1'b0);
    i_pscir_host.write(5'h1e, 16'h0080, 1'b0);
    energy = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk1(energy_present, 1'b1);
    chk1(irq, 1'b1);
    rd_exp(5'h1d, 16'h0080);
    i_pscir_host.write(5'h1f, 16'hffff, 1'b1);
    rd_exp(5'h1f, {3'h0, status.negotiation_done, 7'h7f, status.resolved_link_mode, 2'h0});
    i_pscir_host.write(5'h1b, 16'h8400, 1'b0);
    soft_reset = 1'b1;
    @(negedge ref_clk);
    soft_reset = 1'b0;
    rd_exp(5'h1b, {6'h01, 5'h0, status.rx_polarity_reversed, 4'h0});
    rd_exp(5'h1e, 16'h0000);
    rd_exp(5'h1f, {3'h0, status.negotiation_done, 7'h02, status.resolved_link_mode, 2'h0});
    repeat (4) @(negedge ref_clk);
    chk1(exp_q.size() == 0, 1'b1);
    finish_test();
  end
endmodule
